// ===== verilog/timer_capture_compare.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module timer_capture_compare
  import tcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  input  wire logic [1:0]  cap_pin,
  input  wire logic [7:0]  radio_events,
  output logic      [1:0]  cmp_out,
  output logic      [1:0]  irq_req,
  output logic             dsm_enable,
  output logic             dsm_speed,
  output logic             dsm_interp_en,
  output logic             dsm_shaping_en,
  output logic      [15:0] dsm_sample,
  output logic             dsm_sample_load,
  output logic             dsm_step
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] cnt;
    logic        cnt_down;
    tmode_type   tmode;
    logic [15:0] cc0;
    logic [15:0] cc1;
    logic [7:0]  low_buf;
    logic [7:0]  cnt_hi_buf;
    ctl_type     ctl0;
    ctl_type     ctl1;
    logic [7:0]  radio_event_mask;
    logic [1:0]  flag;
    logic [1:0]  out;
    logic [1:0]  irq;
    logic [7:0]  rdata;
    dsm_cfg_type dsm;
    logic [15:0] dsm_sample;
    logic        dsm_load;
  } cc_state_type;

  cc_state_type r;
  cc_state_type s;
  logic [1:0]   cap_trig;
  logic [1:0]   arm;
  logic [1:0]   edge_src;
  logic [1:0]   src_sel;
  logic [3:0]   edge_sel;
  logic         radio_hit;
  logic         dsm_on;
  logic         running;
  logic         at_top;
  logic         match0;
  logic         match1;
  logic         zero;
  logic         updn;
  logic [1:0]   ev;
  logic [1:0]   clr;
  logic [7:0]   rd_val;

  // ----------------------------------------
  // compare action
  // ----------------------------------------
  // new output level for one channel, win enables codes 101/110
  function automatic logic next_out(cmp_type c, logic cur, logic m, logic m0, logic z,
                                    logic up, logic ud, logic win);
    next_out = cur;
    unique case (c)
      CMP_SET: begin
        if (m) next_out = 1'b1;
      end
      CMP_CLR: begin
        if (m) next_out = 1'b0;
      end
      CMP_TOG: begin
        if (m) next_out = ~cur;
      end
      CMP_UP_SET: begin
        if (m && up) next_out = 1'b1;
        if (ud && m && !up) next_out = 1'b0;
        if (!ud && z) next_out = 1'b0;
      end
      CMP_UP_CLR: begin
        if (m && up) next_out = 1'b0;
        if (ud && m && !up) next_out = 1'b1;
        if (!ud && z) next_out = 1'b1;
      end
      CMP_WIN_SET: begin
        if (win && m) next_out = 1'b1;
        if (win && m0) next_out = 1'b0;
      end
      CMP_WIN_CLR: begin
        if (win && m) next_out = 1'b0;
        if (win && m0) next_out = 1'b1;
      end
      CMP_DSM: begin
        next_out = cur;
      end
    endcase
  endfunction

  // ----------------------------------------
  // capture front ends
  // ----------------------------------------
  assign radio_hit = |(radio_events & r.radio_event_mask);
  assign dsm_on    = (r.ctl1.compare_action_select == CMP_DSM);
  assign arm       = {~r.ctl1.mode & ~dsm_on, ~r.ctl0.mode};
  assign src_sel   = {r.ctl1.capture_source_select, r.ctl0.capture_source_select};
  assign edge_sel  = {r.ctl1.capture_edge_select, r.ctl0.capture_edge_select};
  assign edge_src  = cap_pin;

  // one edge unit per channel
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_cap
      capture_edge_unit u_cap (
        .clk        (clk),
        .resetn     (resetn),
        .pin        (edge_src[ch]),
        .radio_hit  (radio_hit),
        .edge_sel   (edge_sel[2*ch +: 2]),
        .source_sel (src_sel[ch]),
        .arm        (arm[ch]),
        .trig       (cap_trig[ch])
      );
    end
  endgenerate

  // modulator step timing
  dsm_rate_gen u_rate (
    .clk    (clk),
    .resetn (resetn),
    .run    (r.dsm.en),
    .fast   (r.dsm.fast),
    .step   (dsm_step)
  );

  // ----------------------------------------
  // counter conditions
  // ----------------------------------------
  assign running = (r.tmode != TM_STOP);
  assign updn    = (r.tmode == TM_UPDN);
  assign at_top  = (r.tmode == TM_FREE) ? (r.cnt == CNT_MAX) : (r.cnt == r.cc0);
  assign match0  = running && (r.cnt == r.cc0);
  assign match1  = running && (r.cnt == r.cc1);
  assign zero    = running && (r.cnt == CNT_ZERO);

  // events that raise the flags
  assign ev[0] = cap_trig[0] | (r.ctl0.mode & match0);
  assign ev[1] = cap_trig[1] | (r.ctl1.mode & ~dsm_on & match1);

  // flag bits cleared by writing zero
  assign clr = (wr_en && addr == ADDR_TCTL) ? ~{wdata[FLAG1_BIT], wdata[FLAG0_BIT]} : 2'h0;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_val = BYTE_ZERO;
    unique case (addr)
      ADDR_CC0_LOW:  rd_val = r.cc0[7:0];
      ADDR_CC0_HIGH: rd_val = r.cc0[15:8];
      ADDR_CC1_LOW:  rd_val = r.cc1[7:0];
      ADDR_CC1_HIGH: rd_val = r.cc1[15:8];
      ADDR_CNT_LOW:  rd_val = r.cnt[7:0];
      ADDR_CNT_HIGH: rd_val = r.cnt_hi_buf;
      ADDR_TCTL:     rd_val = {1'b0, r.flag, 3'h0, r.tmode};
      ADDR_CTL0:     rd_val = r.ctl0;
      ADDR_CTL1:     rd_val = r.ctl1;
      ADDR_RMASK:    rd_val = r.radio_event_mask;
      default:       rd_val = BYTE_ZERO;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s = r;
    // counter walk per timer mode
    unique case (r.tmode)
      TM_STOP: s.cnt = r.cnt;
      TM_FREE: s.cnt = r.cnt + CNT_ONE;
      TM_MOD: begin
        s.cnt = at_top ? CNT_ZERO : r.cnt + CNT_ONE;
      end
      TM_UPDN: begin
        if (!r.cnt_down) begin
          if (at_top) begin
            s.cnt_down = (r.cnt != CNT_ZERO);
            s.cnt      = (r.cnt == CNT_ZERO) ? CNT_ZERO : r.cnt - CNT_ONE;
          end else begin
            s.cnt = r.cnt + CNT_ONE;
          end
        end else if (r.cnt == CNT_ZERO) begin
          s.cnt_down = 1'b0;
          s.cnt      = CNT_ONE;
        end else begin
          s.cnt = r.cnt - CNT_ONE;
        end
      end
    endcase
    if (!updn) begin
      s.cnt_down = 1'b0;
    end
    // register writes
    if (wr_en) begin
      unique case (addr)
        ADDR_CC0_LOW:  s.cc0[7:0] = wdata;
        ADDR_CC0_HIGH: s.cc0[15:8] = wdata;
        ADDR_CC1_LOW: begin
          if (dsm_on) begin
            s.low_buf = wdata;
          end else begin
            s.cc1[7:0] = wdata;
          end
        end
        ADDR_CC1_HIGH: begin
          s.cc1 = {wdata, dsm_on ? r.low_buf : r.cc1[7:0]};
        end
        ADDR_CNT_LOW: begin
          s.cnt      = CNT_ZERO;
          s.cnt_down = 1'b0;
        end
        ADDR_TCTL:  s.tmode = tmode_type'(wdata[1:0]);
        ADDR_CTL0:  s.ctl0 = ctl_type'(wdata);
        ADDR_CTL1:  s.ctl1 = ctl_type'(wdata);
        ADDR_RMASK: s.radio_event_mask = wdata;
        default:    s.tmode = s.tmode;
      endcase
    end
    // capture overrides a software write
    if (cap_trig[0]) begin
      s.cc0 = r.cnt;
    end
    if (cap_trig[1]) begin
      s.cc1 = r.cnt;
    end
    // flags: set wins over clear
    s.flag = (r.flag & ~clr) | ev;
    s.irq  = r.flag & {r.ctl1.channel_irq_mask, r.ctl0.channel_irq_mask};
    // compare outputs
    if (r.ctl0.mode) begin
      s.out[0] = next_out(r.ctl0.compare_action_select, r.out[0], match0, 1'b0, zero,
                          ~r.cnt_down, updn, 1'b0);
    end
    if (r.ctl1.mode && !dsm_on) begin
      s.out[1] = next_out(r.ctl1.compare_action_select, r.out[1], match1, match0, zero,
                          ~r.cnt_down, updn, 1'b1);
    end
    // modulator configuration
    s.dsm.en     = dsm_on;
    s.dsm.fast   = r.ctl1.mode;
    s.dsm.interp = ~r.ctl1.capture_edge_select[1];
    s.dsm.shape  = ~r.ctl1.capture_edge_select[0];
    // new sample once per channel 0 period in modulo mode
    s.dsm_load = dsm_on && (r.tmode == TM_MOD) && at_top;
    if (s.dsm_load) begin
      s.dsm_sample = r.cc1 & DSM_LSB_MASK;
    end
    // read data for one cycle, high count byte latched on low read
    s.rdata = rd_en ? rd_val : BYTE_ZERO;
    if (rd_en && addr == ADDR_CNT_LOW) begin
      s.cnt_hi_buf = r.cnt[15:8];
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r      <= '0;
      r.ctl0 <= ctl_type'(CTL_RESET);
      r.ctl1 <= ctl_type'(CTL_RESET);
    end else begin
      r <= s;
    end
  end

  // outputs straight from flops
  assign rdata           = r.rdata;
  assign cmp_out         = r.out;
  assign irq_req         = r.irq;
  assign dsm_enable      = r.dsm.en;
  assign dsm_speed       = r.dsm.fast;
  assign dsm_interp_en   = r.dsm.interp;
  assign dsm_shaping_en  = r.dsm.shape;
  assign dsm_sample      = r.dsm_sample;
  assign dsm_sample_load = r.dsm_load;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_set_on_match;
    (r.ctl0.mode && r.ctl0.compare_action_select == CMP_SET && match0) |=> cmp_out[0];
  endproperty
  a_set_on_match: assert property (p_set_on_match) else $error("set on match failed");

  property p_toggle;
    (r.ctl0.mode && r.ctl0.compare_action_select == CMP_TOG && match0)
      |=> (cmp_out[0] != $past(cmp_out[0]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match failed");

  property p_window_set;
    (r.ctl1.mode && r.ctl1.compare_action_select == CMP_WIN_SET && match1 && !match0)
      |=> cmp_out[1];
  endproperty
  a_window_set: assert property (p_window_set) else $error("window set failed");

  property p_window_clr;
    (r.ctl1.mode && r.ctl1.compare_action_select == CMP_WIN_CLR && match0 && !match1)
      |=> cmp_out[1];
  endproperty
  a_window_clr: assert property (p_window_clr) else $error("window clear code set failed");

  property p_mask_blocks;
    (!r.ctl0.channel_irq_mask && !$past(r.ctl0.channel_irq_mask)) |-> !irq_req[0];
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked irq seen");

  property p_capture_copy;
    cap_trig[1] |=> (r.cc1 == $past(r.cnt)) && r.flag[1];
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture copy failed");

  property p_modulo_wrap;
    (r.tmode == TM_MOD && r.cnt == r.cc0 && !wr_en) |=> (r.cnt == CNT_ZERO);
  endproperty
  a_modulo_wrap: assert property (p_modulo_wrap) else $error("modulo wrap failed");

  property p_sample_lsb;
    dsm_sample_load |-> (dsm_sample[1:0] == 2'h0) && (dsm_sample[15:2] == $past(r.cc1[15:2]));
  endproperty
  a_sample_lsb: assert property (p_sample_lsb) else $error("sample format wrong");

  property p_flag_irq;
    (ev[1] && r.ctl1.channel_irq_mask) ##1 r.ctl1.channel_irq_mask |=> irq_req[1];
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag did not reach irq");

endmodule // timer_capture_compare

// ===== inc/tcc_pkg.sv
package tcc_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CC0_LOW  = 8'hDA;
  localparam logic [7:0] ADDR_CC0_HIGH = 8'hDB;
  localparam logic [7:0] ADDR_CC1_LOW  = 8'hDC;
  localparam logic [7:0] ADDR_CC1_HIGH = 8'hDD;
  localparam logic [7:0] ADDR_CNT_LOW  = 8'hE2;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'hE3;
  localparam logic [7:0] ADDR_TCTL     = 8'hE4;
  localparam logic [7:0] ADDR_CTL0     = 8'hE5;
  localparam logic [7:0] ADDR_CTL1     = 8'hE6;
  localparam logic [7:0] ADDR_RMASK    = 8'hE9;

  // ----------------------------------------
  // fields, reset values, constants
  // ----------------------------------------
  localparam int          FLAG0_BIT    = 5;
  localparam int          FLAG1_BIT    = 6;
  localparam logic [7:0]  CTL_RESET    = 8'h40;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_ONE      = 16'h0001;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] DSM_LSB_MASK = 16'hFFFC;
  localparam logic [2:0]  DSM_LAST_SLOW = 3'h7;  // divide by 8
  localparam logic [2:0]  DSM_LAST_FAST = 3'h3;  // divide by 4
  localparam logic [1:0]  CAP_NONE     = 2'h0;
  localparam logic [1:0]  CAP_RISE     = 2'h1;
  localparam logic [1:0]  CAP_FALL     = 2'h2;
  localparam logic [1:0]  CAP_BOTH     = 2'h3;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMP_SET     = 3'h0,
    CMP_CLR     = 3'h1,
    CMP_TOG     = 3'h2,
    CMP_UP_SET  = 3'h3,
    CMP_UP_CLR  = 3'h4,
    CMP_WIN_SET = 3'h5,
    CMP_WIN_CLR = 3'h6,
    CMP_DSM     = 3'h7
  } cmp_type;

  typedef enum logic [1:0] {
    TM_STOP = 2'h0,
    TM_FREE = 2'h1,
    TM_MOD  = 2'h2,
    TM_UPDN = 2'h3
  } tmode_type;

  typedef struct packed {
    logic       capture_source_select;
    logic       channel_irq_mask;
    cmp_type    compare_action_select;
    logic       mode;
    logic [1:0] capture_edge_select;
  } ctl_type;

  typedef struct packed {
    logic en;
    logic fast;
    logic interp;
    logic shape;
  } dsm_cfg_type;

endpackage

// ===== verilog/capture_edge_unit.sv
`timescale 1ns/1ps
module capture_edge_unit
  import tcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       pin,
  input  wire logic       radio_hit,
  input  wire logic [1:0] edge_sel,
  input  wire logic       source_sel,
  input  wire logic       arm,
  output logic            trig
);
  typedef struct packed {
    logic pin_prev;
    logic trig;
  } cap_state_type;

  cap_state_type r;
  cap_state_type s;
  logic          rise;
  logic          fall;

  // edge pick or radio source
  always_comb begin
    s          = r;
    rise       = pin & ~r.pin_prev;
    fall       = ~pin & r.pin_prev;
    s.pin_prev = pin;
    if (source_sel) begin
      s.trig = arm & radio_hit & (edge_sel != CAP_NONE);
    end else begin
      s.trig = arm & (((edge_sel == CAP_RISE) & rise) | ((edge_sel == CAP_FALL) & fall) |
                      ((edge_sel == CAP_BOTH) & (rise | fall)));
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign trig = r.trig;
endmodule // capture_edge_unit

// ===== verilog/dsm_rate_gen.sv
`timescale 1ns/1ps
module dsm_rate_gen
  import tcc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic run,
  input  wire logic fast,
  output logic      step
);
  typedef struct packed {
    logic [2:0] div;
    logic       step;
  } rate_state_type;

  rate_state_type r;
  rate_state_type s;
  logic [2:0]     last;

  // modulator step at 1/8 or 1/4 of the tick
  always_comb begin
    s      = r;
    last   = fast ? DSM_LAST_FAST : DSM_LAST_SLOW;
    s.step = 1'b0;
    if (!run) begin
      s.div = 3'h0;
    end else if (r.div >= last) begin
      s.div  = 3'h0;
      s.step = 1'b1;
    end else begin
      s.div = r.div + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign step = r.step;
endmodule // dsm_rate_gen

// ===== testbench/pin_partner.sv
`timescale 1ns/1ps
module pin_partner
  import tcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] pin_cmd,
  input  wire logic [7:0] radio_cmd,
  output logic      [1:0] cap_pin,
  output logic      [7:0] radio_events
);
  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  // pins follow the command one edge later, like a synchronous source
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_pin      <= 2'h0;
      radio_events <= 8'h00;
    end else begin
      cap_pin      <= pin_cmd;
      radio_events <= radio_cmd;
    end
  end
endmodule // pin_partner

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import tcc_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        resetn, wr_en, rd_en, rd_d;
  logic [7:0]  addr, wdata, rdata, radio_cmd, radio_events;
  logic [1:0]  pin_cmd, cap_pin, cmp_out, irq_req;
  logic        dsm_enable, dsm_speed, dsm_interp_en, dsm_shaping_en, dsm_sample_load, dsm_step;
  logic [15:0] dsm_sample, v;
  logic [7:0]  exp_q[$];
  int          mismatches, num_checks, cycles;
  int unsigned seed_v;
  int          codes[7]  = '{2, 3, 4, 5, 6, 3, 4};
  int          lvls[7]   = '{1, 1, 0, 1, 1, 1, 0};
  int          spans[7]  = '{7, 5, 5, 4, 3, 8, 8};
  int          tmodes[7] = '{2, 2, 2, 2, 2, 3, 3};

  timer_capture_compare dut_u (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .cap_pin(cap_pin), .radio_events(radio_events), .cmp_out(cmp_out),
    .irq_req(irq_req), .dsm_enable(dsm_enable), .dsm_speed(dsm_speed),
    .dsm_interp_en(dsm_interp_en), .dsm_shaping_en(dsm_shaping_en), .dsm_sample(dsm_sample),
    .dsm_sample_load(dsm_sample_load), .dsm_step(dsm_step));

  pin_partner partner_u (
    .clk(clk), .resetn(resetn), .pin_cmd(pin_cmd), .radio_cmd(radio_cmd),
    .cap_pin(cap_pin), .radio_events(radio_events));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // clock, 40 ns period
  always #20 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] e);
    num_checks++;
    if (seen !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, e, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // read data compared against the oldest note, one cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) check("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
    rd_d <= rd_en;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  function automatic logic [7:0] ctl(input logic s, m, input logic [2:0] c, input logic md,
                                     input logic [1:0] cp);
    return {s, m, c, md, cp};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  // stop, clear counter, write a control register, start in mode m
  task automatic restart(input logic [7:0] a, input logic [7:0] c, input logic [7:0] m);
    wr(ADDR_TCTL, 8'h60);
    wr(ADDR_CNT_LOW, 8'h00);
    wr(a, c);
    wr(ADDR_TCTL, m | 8'h60);
  endtask

  task automatic wait_cmp(input int ch, input logic l);
    int n;
    n = 0;
    while (cmp_out[ch] !== l && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask

  // cycles that a compare output stays at level l
  task automatic span(input int ch, input logic l, input int e);
    int n;
    wait_cmp(ch, ~l);
    wait_cmp(ch, l);
    n = 0;
    while (cmp_out[ch] === l && n < 300) begin
      @(posedge clk);
      n++;
    end
    check("span", n[15:0], e[15:0]);
  endtask

  // cycles between two pulses of the step (0) or sample load (1)
  task automatic gap(input int w, input int e);
    int n;
    n = 0;
    while ((w ? dsm_sample_load : dsm_step) !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((w ? dsm_sample_load : dsm_step) !== 1'b1 && n < 100);
    check("gap", n[15:0], e[15:0]);
  endtask

  // move the capture pins, then read and clear the flags
  task automatic edge_flag(input logic [1:0] p, input logic [7:0] e);
    pin_cmd <= p;
    repeat (6) @(posedge clk);
    rd(ADDR_TCTL, e);
    wr(ADDR_TCTL, 8'h00);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pin_cmd = 2'h0;
    radio_cmd = 8'h00;
    seed_v = $urandom(52);
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTL0, CTL_RESET);
    rd(ADDR_CTL1, CTL_RESET);
    rd(ADDR_CC0_HIGH, BYTE_ZERO);
    rd(8'h10, BYTE_ZERO);
    check("irq", {14'h0, irq_req}, 16'h0);
    v = 16'($urandom);
    wr(ADDR_CC0_LOW, v[7:0]);
    wr(ADDR_CC0_HIGH, v[15:8]);
    rd(ADDR_CC0_LOW, v[7:0]);
    rd(ADDR_CC0_HIGH, v[15:8]);
    // channel 0 set, clear, toggle, modulo period of 6
    wr(ADDR_CC0_LOW, 8'h05);
    wr(ADDR_CC0_HIGH, 8'h00);
    for (int c = 0; c < 3; c++) begin
      restart(ADDR_CTL0, ctl(1'b0, 1'b1, c[2:0], 1'b1, CAP_NONE), 8'h02);
      repeat (20) @(posedge clk);
      if (c < 2) check("cmp0", {15'h0, cmp_out[0]}, {15'h0, c == 0});
    end
    span(0, 1'b1, 6);
    rd(ADDR_TCTL, 8'h22);
    check("irq0", {15'h0, irq_req[0]}, 16'h1);
    wr(ADDR_CTL0, ctl(1'b0, 1'b0, CMP_TOG, 1'b1, CAP_NONE));
    repeat (3) @(posedge clk);
    check("irq0", {15'h0, irq_req[0]}, 16'h0);
    wr(ADDR_TCTL, 8'h60);
    wr(ADDR_TCTL, 8'h00);
    rd(ADDR_TCTL, 8'h00);
    // channel 1 actions, channel 0 at 6 and channel 1 at 2
    wr(ADDR_CC0_LOW, 8'h06);
    wr(ADDR_CC1_LOW, 8'h02);
    wr(ADDR_CC1_HIGH, 8'h00);
    for (int i = 0; i < 7; i++) begin
      restart(ADDR_CTL1, ctl(1'b0, 1'b1, codes[i][2:0], 1'b1, CAP_NONE), tmodes[i][7:0]);
      span(1, lvls[i][0], spans[i]);
    end
    // capture edges on channel 1, counter stopped at zero
    wr(ADDR_TCTL, 8'h00);
    wr(ADDR_CNT_LOW, 8'h00);
    wr(ADDR_CC1_LOW, 8'hFF);
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_CTL1, ctl(1'b0, 1'b1, CMP_SET, 1'b0, e[1:0]));
      edge_flag(2'b10, {1'b0, e[0], 6'h0});
      edge_flag(2'b00, {1'b0, e[1], 6'h0});
    end
    rd(ADDR_CC1_LOW, 8'h00);
    wr(ADDR_RMASK, 8'h01);
    wr(ADDR_CTL1, ctl(1'b1, 1'b1, CMP_SET, 1'b0, CAP_RISE));
    edge_flag(2'b10, 8'h00);
    radio_cmd <= 8'h02;
    edge_flag(2'b10, 8'h00);
    radio_cmd <= 8'h01;
    edge_flag(2'b10, 8'h40);
    radio_cmd <= 8'h00;
    // modulator configuration, step rate and samples
    wr(ADDR_CC0_LOW, 8'h09);
    wr(ADDR_CTL0, ctl(1'b0, 1'b1, CMP_SET, 1'b1, CAP_NONE));
    for (int k = 0; k < 8; k++) begin
      restart(ADDR_CTL1, ctl(1'b0, 1'b1, CMP_DSM, k[2], k[1:0]), 8'h02);
      check("dsm", {12'h0, dsm_enable, dsm_speed, dsm_interp_en, dsm_shaping_en},
            {13'h1, k[2], ~k[1], ~k[0]});
      gap(0, k[2] ? 4 : 8);
    end
    v = 16'($urandom);
    wr(ADDR_CC1_LOW, v[7:0]);
    wr(ADDR_CC1_HIGH, v[15:8]);
    gap(1, 10);
    check("sample", dsm_sample, v & DSM_LSB_MASK);
    tally_and_finish();
  end
endmodule // tb_top
